// *** hw/sss_pkg.sv ***
package sss_pkg;

  // Operating modes of synchronous control.
  typedef enum logic {
    SSS_MODE_COMMAND,
    SSS_MODE_SIGNAL
  } sss_mode_t;

  localparam int SSS_SPEED_W = 16;
  localparam int SSS_PHASE_W = 16;
  localparam int SSS_VOLT_W = 12;

  // Battery threshold in millivolts, and its default code at 1 mV per count.
  localparam int SSS_BATT_THRESH_MV = 2600;
  localparam logic [SSS_VOLT_W-1:0] SSS_BATT_THRESH_CODE = SSS_VOLT_W'(SSS_BATT_THRESH_MV);

  // Cycles after reset release before the battery voltage is sampled.
  localparam int SSS_CLK_HZ = 20_000_000;
  localparam int SSS_BATT_SETTLE_US = 100;
  localparam int SSS_BATT_SETTLE_CYC = (SSS_BATT_SETTLE_US * (SSS_CLK_HZ / 1_000_000));
  localparam int SSS_SETTLE_W = 12;

  localparam logic [SSS_SPEED_W-1:0] SSS_SPEED_ZERO = 16'h0000;

  typedef struct packed {
    logic sync_request;
    logic sync_cancel_request;
    logic phase_sync_request;
    logic chuck_close_req;
    logic sync_start_command;
    logic sync_end_command;
  } sss_seq_req_t;

  typedef struct packed {
    logic [SSS_SPEED_W-1:0] cmd_speed;
    logic [SSS_SPEED_W-1:0] basic_speed;
    logic [SSS_SPEED_W-1:0] sync_speed;
    logic [SSS_PHASE_W-1:0] phase_diff;
    logic phase_aligned;
  } sss_spindle_meas_t;

  typedef struct packed {
    logic sync_mode_active;
    logic speed_sync_done;
    logic phase_sync_done;
    logic chuck_close_ack;
  } sss_sync_stat_t;

  typedef struct packed {
    logic battery_low_flag;
    logic system_error_flag;
    logic servo_alarm_flag;
    logic servo_ready_all;
    logic auto_start_allowed;
  } sss_alarm_stat_t;

endpackage : sss_pkg

// *** hw/sss_absdiff.sv ***
`timescale 1ns/100ps
module sss_absdiff #(
  parameter int W = 16
) (
  input wire logic [W-1:0] a,
  input wire logic [W-1:0] b,
  output logic [W-1:0] diff
);
  if (W < 2) begin : g_bad_width
    $error("sss_absdiff: width too small");
  end

  always_comb begin
    diff = (a >= b) ? (a - b) : (b - a);
  end
endmodule : sss_absdiff

// *** hw/sss_batt_check.sv ***
`timescale 1ns/100ps
module sss_batt_check
  import sss_pkg::*;
#(
  parameter int SETTLE_CYC = SSS_BATT_SETTLE_CYC
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [SSS_VOLT_W-1:0] batt_voltage,
  input wire logic [SSS_VOLT_W-1:0] batt_threshold,
  input wire logic display_reset,
  output logic batt_low
);
  import sss_pkg::*;

  if (SETTLE_CYC < 1 || SETTLE_CYC >= (1 << SSS_SETTLE_W)) begin : g_bad_settle
    $error("sss_batt_check: bad settle");
  end

  logic [SSS_SETTLE_W-1:0] settle_q;
  logic checked_q;

  // The voltage is looked at exactly once per power-up, after a settle time.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      settle_q <= '0;
      checked_q <= 1'b0;
    end else if (!checked_q) begin
      if (settle_q == SSS_SETTLE_W'(SETTLE_CYC - 1)) begin
        checked_q <= 1'b1;
      end else begin
        settle_q <= settle_q + 1'b1;
      end
    end
  end

  // A display reset clears the flag; it comes back only at the next power-up.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      batt_low <= 1'b0;
    end else if (!checked_q && settle_q == SSS_SETTLE_W'(SETTLE_CYC - 1)) begin
      batt_low <= (batt_voltage < batt_threshold);
    end else if (display_reset) begin
      batt_low <= 1'b0;
    end
  end
endmodule : sss_batt_check

// *** hw/sss_status_flags.sv ***
`timescale 1ns/100ps
// Behaviour
// - Command mode: start command sets sync_mode_active.
// - Signal mode: sync_request high sets sync_mode_active.
// - Command mode: end command or cancel request clears sync_mode_active.
// - Signal mode: sync_request low clears sync_mode_active.
// - In sync mode, speed difference within level sets speed_sync_done.
// - Either spindle off commanded speed beyond level clears speed_sync_done.
// - Leaving sync mode clears speed and phase done flags.
// - In phase mode, completed alignment sets phase_sync_done.
// - In phase mode, phase difference beyond level clears phase_sync_done.
// - chuck_close_ack follows chuck_close_req in sync mode, low otherwise.
// - Battery checked at power-up; low voltage sets battery_low_flag.
// - Detector supply faults also set battery_low_flag.
// - Voltage cause clears on display reset; supply causes clear on power cycle.
// - Auto start allowed for battery and detector supply causes, not speed detector.
// - Watchdog or parity error sets system_error_flag until power removal.
// - Servo alarm sets servo_alarm_flag and drops servo_ready_all together.
module sss_status_flags
  import sss_pkg::*;
#(
  parameter int SETTLE_CYC = SSS_BATT_SETTLE_CYC
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire sss_pkg::sss_mode_t mode,
  input wire sss_pkg::sss_seq_req_t seq_req,
  input wire sss_pkg::sss_spindle_meas_t meas,
  input wire logic [SSS_SPEED_W-1:0] speed_level,
  input wire logic [SSS_PHASE_W-1:0] phase_level,
  input wire logic [SSS_VOLT_W-1:0] batt_voltage,
  input wire logic display_reset,
  input wire logic abs_supply_fault,
  input wire logic speed_det_supply_fault,
  input wire logic watchdog_error,
  input wire logic parity_error,
  input wire logic servo_alarm,
  input wire logic servo_diag_ok,
  output sss_pkg::sss_sync_stat_t sync_stat,
  output sss_pkg::sss_alarm_stat_t alarm_stat
);
  import sss_pkg::*;

  logic sync_q;
  logic sync_d;
  logic speed_done_q;
  logic phase_done_q;
  logic ack_q;
  logic abs_fault_q;
  logic spd_fault_q;
  logic syserr_q;
  logic servo_alarm_q;
  logic ready_q;
  logic auto_ok_q;
  logic batt_flag_q;
  logic batt_volt_low;
  logic [SSS_SPEED_W-1:0] d_bs;
  logic [SSS_SPEED_W-1:0] d_bc;
  logic [SSS_SPEED_W-1:0] d_sc;

  sss_absdiff #(.W(SSS_SPEED_W)) u_diff_bs (
    .a(meas.basic_speed),
    .b(meas.sync_speed),
    .diff(d_bs)
  );

  sss_absdiff #(.W(SSS_SPEED_W)) u_diff_bc (
    .a(meas.basic_speed),
    .b(meas.cmd_speed),
    .diff(d_bc)
  );

  sss_absdiff #(.W(SSS_SPEED_W)) u_diff_sc (
    .a(meas.sync_speed),
    .b(meas.cmd_speed),
    .diff(d_sc)
  );

  sss_batt_check #(.SETTLE_CYC(SETTLE_CYC)) u_batt (
    .clk_sys(clk_sys),
    .srst(srst),
    .batt_voltage(batt_voltage),
    .batt_threshold(SSS_BATT_THRESH_CODE),
    .display_reset(display_reset),
    .batt_low(batt_volt_low)
  );

  // Mode entry and exit; in command mode an end or cancel outranks a start.
  always_comb begin
    sync_d = sync_q;
    case (mode)
      SSS_MODE_COMMAND: begin
        if (seq_req.sync_end_command || seq_req.sync_cancel_request) begin
          sync_d = 1'b0;
        end else if (seq_req.sync_start_command) begin
          sync_d = 1'b1;
        end
      end
      SSS_MODE_SIGNAL: begin
        sync_d = seq_req.sync_request;
      end
      default: begin
        sync_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sync_q <= 1'b0;
    end else begin
      sync_q <= sync_d;
    end
  end

  // Done flags look at the next mode value so they drop in the same cycle as the mode.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      speed_done_q <= 1'b0;
    end else if (!sync_d) begin
      speed_done_q <= 1'b0;
    end else if (d_bc > speed_level || d_sc > speed_level) begin
      speed_done_q <= 1'b0;
    end else if (d_bs <= speed_level) begin
      speed_done_q <= 1'b1;
    end
  end

  // Phase alignment is only judged while phase synchronization is requested.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      phase_done_q <= 1'b0;
    end else if (!sync_d) begin
      phase_done_q <= 1'b0;
    end else if (seq_req.phase_sync_request) begin
      if (meas.phase_diff > phase_level) begin
        phase_done_q <= 1'b0;
      end else if (meas.phase_aligned) begin
        phase_done_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= sync_d && seq_req.chuck_close_req;
    end
  end

  // Supply faults latch until power is cycled, even if the fault itself goes away.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      abs_fault_q <= 1'b0;
      spd_fault_q <= 1'b0;
    end else begin
      abs_fault_q <= abs_fault_q || abs_supply_fault;
      spd_fault_q <= spd_fault_q || speed_det_supply_fault;
    end
  end

  // The speed detector fault blocks automatic start; the other battery causes do not.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      auto_ok_q <= 1'b0;
    end else begin
      auto_ok_q <= !(spd_fault_q || speed_det_supply_fault);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      syserr_q <= 1'b0;
    end else begin
      syserr_q <= syserr_q || watchdog_error || parity_error;
    end
  end

  // Ready and alarm flip together in one edge, so the sequence never sees both high.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      servo_alarm_q <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      servo_alarm_q <= servo_alarm;
      ready_q <= servo_diag_ok && !servo_alarm;
    end
  end

  // The battery flag is its own flip-flop so the output never carries a gate glitch.
  // Raw supply faults and the display reset are folded in so its timing matches the latches.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      batt_flag_q <= 1'b0;
    end else begin
      batt_flag_q <= (batt_volt_low && !display_reset) || abs_fault_q || spd_fault_q ||
        abs_supply_fault || speed_det_supply_fault;
    end
  end

  always_comb begin
    sync_stat.sync_mode_active = sync_q;
    sync_stat.speed_sync_done = speed_done_q;
    sync_stat.phase_sync_done = phase_done_q;
    sync_stat.chuck_close_ack = ack_q;
    alarm_stat.battery_low_flag = batt_flag_q;
    alarm_stat.system_error_flag = syserr_q;
    alarm_stat.servo_alarm_flag = servo_alarm_q;
    alarm_stat.servo_ready_all = ready_q;
    alarm_stat.auto_start_allowed = auto_ok_q;
  end
endmodule : sss_status_flags

// *** bench/sss_status_flags_chk.sv ***
`timescale 1ns/100ps
module sss_status_flags_chk
  import sss_pkg::*;
#(
  parameter int SETTLE_CYC = SSS_BATT_SETTLE_CYC
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire sss_pkg::sss_mode_t mode,
  input wire sss_pkg::sss_seq_req_t seq_req,
  input wire sss_pkg::sss_spindle_meas_t meas,
  input wire logic [SSS_SPEED_W-1:0] speed_level,
  input wire logic [SSS_PHASE_W-1:0] phase_level,
  input wire logic [SSS_VOLT_W-1:0] batt_voltage,
  input wire logic display_reset,
  input wire logic abs_supply_fault,
  input wire logic speed_det_supply_fault,
  input wire logic watchdog_error,
  input wire logic parity_error,
  input wire logic servo_alarm,
  input wire logic servo_diag_ok,
  input wire sss_pkg::sss_sync_stat_t sync_stat,
  input wire sss_pkg::sss_alarm_stat_t alarm_stat
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  a_cmd_start: assert property (mode == SSS_MODE_COMMAND && seq_req.sync_start_command &&
    !seq_req.sync_end_command && !seq_req.sync_cancel_request |=> sync_stat.sync_mode_active)
    else $error("sync mode not entered on start command");
  a_cmd_stop: assert property (mode == SSS_MODE_COMMAND &&
    (seq_req.sync_end_command || seq_req.sync_cancel_request) |=> !sync_stat.sync_mode_active)
    else $error("sync mode not left on end or cancel");
  a_sig_enter: assert property (mode == SSS_MODE_SIGNAL && seq_req.sync_request |=>
    sync_stat.sync_mode_active) else $error("sync mode not entered on request");
  a_sig_leave: assert property (mode == SSS_MODE_SIGNAL && !seq_req.sync_request |=>
    !sync_stat.sync_mode_active) else $error("sync mode not left on request low");
  a_done_clear: assert property (!sync_stat.sync_mode_active |->
    !sync_stat.speed_sync_done && !sync_stat.phase_sync_done)
    else $error("done flag set outside sync mode");
  a_ack_follow: assert property (1'b1 |=> sync_stat.chuck_close_ack ==
    (sync_stat.sync_mode_active && $past(seq_req.chuck_close_req)))
    else $error("chuck ack does not follow request");
  a_sys_sticky: assert property (watchdog_error || parity_error ||
    alarm_stat.system_error_flag |=> alarm_stat.system_error_flag)
    else $error("system error flag not held");
  a_servo_pair: assert property (servo_alarm |=>
    alarm_stat.servo_alarm_flag && !alarm_stat.servo_ready_all)
    else $error("servo alarm and ready disagree");
  a_supply_flag: assert property (abs_supply_fault |=> alarm_stat.battery_low_flag)
    else $error("supply fault did not raise battery flag");
  a_auto_block: assert property (speed_det_supply_fault |=>
    !alarm_stat.auto_start_allowed) else $error("auto start left on");
endmodule : sss_status_flags_chk
bind sss_status_flags sss_status_flags_chk #(.SETTLE_CYC(SETTLE_CYC)) i_chk (.clk_sys, .srst,
  .mode, .seq_req, .meas, .speed_level, .phase_level, .batt_voltage, .display_reset,
  .abs_supply_fault, .speed_det_supply_fault, .watchdog_error, .parity_error, .servo_alarm,
  .servo_diag_ok, .sync_stat, .alarm_stat);

// *** bench/sss_seq_model.sv ***
`timescale 1ns/100ps
module sss_seq_model
  import sss_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic want_chuck,
  input wire logic pos_err,
  input wire sss_pkg::sss_sync_stat_t stat,
  output logic chuck_close_req,
  output logic err_cancel
);
  // Error cancel is only used when the spindles still disagree while the chuck close request is held.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      err_cancel <= 1'b0;
    end else begin
      err_cancel <= chuck_close_req && pos_err;
    end
  end

  // Clamping waits for phase completion, since aligning a clamped part twists it.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      chuck_close_req <= 1'b0;
    end else begin
      chuck_close_req <= want_chuck && (stat.phase_sync_done || chuck_close_req);
    end
  end
endmodule : sss_seq_model

// *** bench/tb.sv ***
`timescale 1ns/100ps
module tb;
  import sss_pkg::*;
  logic clk_sys, srst, sreq, scan, sph, sst, sen, want, chuck, drst, absf, spdf, wd, par;
  logic salm, sdiag, ecan;
  sss_mode_t mode;
  sss_seq_req_t seq_req;
  sss_spindle_meas_t meas;
  logic [SSS_VOLT_W-1:0] batt;
  sss_sync_stat_t ss;
  sss_alarm_stat_t al;
  int error_cnt, samples_checked;
  assign seq_req = {sreq, scan, sph, chuck, sst, sen};
  sss_status_flags #(.SETTLE_CYC(4)) i_dut (.clk_sys, .srst, .mode, .seq_req, .meas,
    .speed_level(16'h0010), .phase_level(16'h0008), .batt_voltage(batt), .display_reset(drst),
    .abs_supply_fault(absf), .speed_det_supply_fault(spdf), .watchdog_error(wd),
    .parity_error(par), .servo_alarm(salm), .servo_diag_ok(sdiag), .sync_stat(ss), .alarm_stat(al));
  sss_seq_model i_seq (.clk_sys, .srst, .want_chuck(want), .pos_err(meas.phase_diff > 16'h0008),
    .stat(ss), .chuck_close_req(chuck), .err_cancel(ecan));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : cyc
  task automatic final_report();
    $display("errors=%0d checks=%0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    error_cnt++;
    final_report();
  end
  initial begin
    error_cnt = 0;
    samples_checked = 0;
    srst = 1'b1;
    mode = SSS_MODE_COMMAND;
    {sreq, scan, sph, sst, sen, want, drst, absf, spdf, wd, par, salm} = '0;
    sdiag = 1'b1;
    batt = 12'h0A27;
    meas = '0;
    repeat (8) @(posedge clk_sys);
    cyc(0);
    chk({ss, al}, 16'h0000);
    @(posedge clk_sys);
    srst <= 1'b0;
    meas <= '{16'h0100, 16'h0100, 16'h0108, 16'h0000, 1'b0};
    sst <= 1'b1;
    @(posedge clk_sys);
    sst <= 1'b0;
    cyc(0);
    chk(ss, 4'hC);
    @(posedge clk_sys);
    {sph, meas.phase_aligned, want} <= 3'h7;
    cyc(3);
    chk(ss, 4'hF);
    @(posedge clk_sys);
    meas.phase_diff <= 16'h0009;
    meas.phase_aligned <= 1'b0;
    cyc(1);
    chk({ss, ecan}, 5'h1B);
    @(posedge clk_sys);
    meas.basic_speed <= 16'h0111;
    cyc(1);
    chk(ss, 4'h9);
    @(posedge clk_sys);
    scan <= 1'b1;
    cyc(1);
    chk(ss, 4'h0);
    @(posedge clk_sys);
    {scan, sst, sen} <= 3'h3;
    cyc(1);
    chk(ss.sync_mode_active, 1'h0);
    @(posedge clk_sys);
    sen <= 1'b0;
    cyc(1);
    chk(ss.sync_mode_active, 1'h1);
    @(posedge clk_sys);
    {sst, sen} <= 2'h1;
    cyc(1);
    chk(ss.sync_mode_active, 1'h0);
    @(posedge clk_sys);
    sen <= 1'b0;
    mode <= SSS_MODE_SIGNAL;
    sreq <= 1'b1;
    cyc(1);
    chk(ss.sync_mode_active, 1'h1);
    @(posedge clk_sys);
    sreq <= 1'b0;
    cyc(1);
    chk(ss.sync_mode_active, 1'h0);
    chk({al.battery_low_flag, al.auto_start_allowed, al.servo_ready_all}, 3'h7);
    @(posedge clk_sys);
    drst <= 1'b1;
    cyc(1);
    chk(al.battery_low_flag, 1'h0);
    @(posedge clk_sys);
    {drst, absf} <= 2'h1;
    @(posedge clk_sys);
    {drst, absf} <= 2'h2;
    cyc(2);
    chk({al.battery_low_flag, al.auto_start_allowed}, 2'h3);
    @(posedge clk_sys);
    {drst, spdf} <= 2'h1;
    cyc(1);
    chk(al.auto_start_allowed, 1'h0);
    @(posedge clk_sys);
    {spdf, salm} <= 2'h1;
    cyc(1);
    chk({al.servo_alarm_flag, al.servo_ready_all}, 2'h2);
    @(posedge clk_sys);
    {salm, wd} <= 2'h1;
    @(posedge clk_sys);
    wd <= 1'b0;
    cyc(3);
    chk({al.system_error_flag, al.servo_alarm_flag, al.servo_ready_all}, 3'h5);
    @(posedge clk_sys);
    srst <= 1'b1;
    batt <= 12'h0A28;
    @(posedge clk_sys);
    srst <= 1'b0;
    cyc(0);
    chk(al, 5'h00);
    @(posedge clk_sys);
    par <= 1'b1;
    @(posedge clk_sys);
    par <= 1'b0;
    cyc(8);
    chk({al.system_error_flag, al.battery_low_flag}, 2'h2);
    final_report();
  end
endmodule : tb
